// *** fscr_regs.sv ***
//////////////////////////////////////////////////////////////////////////////////////////////////
// Contract
// - With the write-disable bit set and the protect pin low, register writes are ignored.
// - With the write-disable bit clear, the protect pin gives no register protection.
// - Status bits 4 to 2 pick a protected sector range in which program and erase are refused.
// - Register write, program and erase are taken only while the write-enable latch is set.
// - Only the write-enable and write-disable commands and reset change the write-enable latch.
// - The busy bit is 1 while a register write, program, erase or other operation runs.
// - With the busy bit clear the block is idle and takes new commands.
// - Configuration bits 7 and 6 give the read latency code.
// - Configuration bit 5 anchors protection at low addresses when 1, high when 0.
// - Configuration bit 2 puts the small sectors at the top when 1, the bottom when 0.
// - Configuration bit 1 enables quad operation when 1, else dual or single mode.
// - Configuration bit 0 locks protect bits, protect start, placement and one-time areas.
//////////////////////////////////////////////////////////////////////////////////////////////////
module fscr_regs #(
   parameter int ADDR_W = 8
) (
   // Clock and reset.
   input wire logic I_MCLK,
   input wire logic I_SRST,
   // Command port from the serial front end.
   input wire logic [2:0] i_CMD,
   input wire logic i_CMD_VALID,
   input wire logic [7:0] i_WR_STATUS,
   input wire logic [7:0] i_WR_CONFIG,
   input wire logic i_WR_CONFIG_VALID,
   input wire logic [ADDR_W-1:0] i_SECTOR,
   // Array engine.
   input wire logic i_OP_DONE,
   input wire logic i_OP_FAIL,
   input wire logic i_OTHER_BUSY,
   // Write-protect pin, low active.
   input wire logic i_WP_N,
   // Register read back.
   output logic [7:0] o_STATUS,
   output logic [7:0] o_CONFIG,
   // Engine control.
   output logic o_PROG_START,
   output logic o_ERASE_START,
   output logic o_CMD_REFUSED,
   // Mode outputs.
   output logic [1:0] o_LATENCY_CODE,
   output logic o_QUAD_EN,
   output logic o_PARAM_TOP,
   output logic o_OTP_LOCK
);
   //////////////////////////////////////////////////////////////////////////////////////////////
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_WRR = 3'b010,
      ST_ARRAY = 3'b100
   } fscr_st_e;

   typedef struct packed {
      fscr_st_e st;
      logic [7:0] sr;
      logic [7:0] cr;
      logic [3:0] cnt;
      logic wp_s1;
      logic wp_s2;
      logic prog;
      logic start_p;
      logic start_e;
      logic refused;
      logic [7:0] sr_out;
      logic [7:0] cr_out;
   } fscr_state_s;

   fscr_state_s s_q = '0;
   fscr_state_s s_d;
   logic [7:0] nv_rdata;
   logic nv_we;

   // Protected-range test: the block-protect code gives a power-of-two share of the array.
   function automatic logic in_range(input logic [2:0] bp, input logic from_low,
                                     input logic [ADDR_W-1:0] sec);
      logic [ADDR_W-1:0] span;
      logic hit;
      span = '0;
      hit = 1'b0;
      if (bp == 3'h7) begin
         hit = 1'b1;
      end else if (bp != 3'h0) begin
         span = ADDR_W'(1) << (ADDR_W - 7 + int'(bp));
         if (from_low) begin
            hit = (sec < span);
         end else begin
            hit = (sec >= ADDR_W'(~span + ADDR_W'(1)));
         end
      end
      return hit;
   endfunction : in_range

   // Non-volatile image of the status byte, kept in a separate store.
   fscr_nvstore u_nv (
      .i_clk(I_MCLK),
      .i_we(nv_we),
      .i_addr(1'b0),
      .i_wdata(s_d.sr),
      .i_raddr(1'b0),
      .o_rdata(nv_rdata)
   );
   assign nv_we = (s_q.st == ST_WRR) && (s_q.cnt == 4'h1);

   //////////////////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic write_enable_latch;
      logic locked;
      logic frz;
      write_enable_latch = s_q.sr[fscr_pkg::SR_WEL];
      locked = s_q.sr[fscr_pkg::SR_SWD] && !s_q.wp_s2;
      frz = s_q.cr[fscr_pkg::CR_FREEZE];
      s_d = s_q;
      s_d.wp_s1 = i_WP_N;
      s_d.wp_s2 = s_q.wp_s1;
      s_d.start_p = 1'b0;
      s_d.start_e = 1'b0;
      s_d.refused = 1'b0;
      case (s_q.st)
         ST_IDLE: begin
            if (i_CMD_VALID && !i_OTHER_BUSY) begin
               case (i_CMD)
                  fscr_pkg::FSCR_CMD_WRITE_ENABLE_CMD: s_d.sr[fscr_pkg::SR_WEL] = 1'b1;
                  fscr_pkg::FSCR_CMD_WRITE_DISABLE_CMD: s_d.sr[fscr_pkg::SR_WEL] = 1'b0;
                  fscr_pkg::FSCR_CMD_WRR: begin
                     if (!write_enable_latch || locked) begin
                        s_d.refused = 1'b1;
                     end else begin
                        s_d.sr[fscr_pkg::SR_SWD] = i_WR_STATUS[fscr_pkg::SR_SWD];
                        if (!frz) begin
                           s_d.sr[fscr_pkg::SR_BP_HI:fscr_pkg::SR_BP_LO] =
                              i_WR_STATUS[fscr_pkg::SR_BP_HI:fscr_pkg::SR_BP_LO];
                        end
                        if (i_WR_CONFIG_VALID) begin
                           s_d.cr[7:6] = i_WR_CONFIG[7:6];
                           s_d.cr[fscr_pkg::CR_QUAD] = i_WR_CONFIG[fscr_pkg::CR_QUAD];
                           s_d.cr[fscr_pkg::CR_FREEZE] = i_WR_CONFIG[fscr_pkg::CR_FREEZE]
                              | frz;
                           // One-time bits only move from 0 to 1; protect start and placement not while frozen.
                           s_d.cr[fscr_pkg::CR_BPVOL] = s_q.cr[fscr_pkg::CR_BPVOL]
                              | i_WR_CONFIG[fscr_pkg::CR_BPVOL];
                           if (!frz) begin
                              s_d.cr[fscr_pkg::CR_PSTART] = s_q.cr[fscr_pkg::CR_PSTART]
                                 | i_WR_CONFIG[fscr_pkg::CR_PSTART];
                              s_d.cr[fscr_pkg::CR_PARAM] = s_q.cr[fscr_pkg::CR_PARAM]
                                 | i_WR_CONFIG[fscr_pkg::CR_PARAM];
                           end
                        end
                        s_d.cnt = 4'(fscr_pkg::WR_BUSY_CYC);
                        s_d.st = ST_WRR;
                     end
                  end
                  fscr_pkg::FSCR_CMD_PROG, fscr_pkg::FSCR_CMD_ERASE: begin
                     if (!write_enable_latch || in_range(s_q.sr[4:2], s_q.cr[fscr_pkg::CR_PSTART],
                                           i_SECTOR)) begin
                        s_d.refused = 1'b1;
                     end else begin
                        s_d.prog = (i_CMD == fscr_pkg::FSCR_CMD_PROG);
                        s_d.start_p = (i_CMD == fscr_pkg::FSCR_CMD_PROG);
                        s_d.start_e = (i_CMD == fscr_pkg::FSCR_CMD_ERASE);
                        s_d.sr[fscr_pkg::SR_PERR] = 1'b0;
                        s_d.sr[fscr_pkg::SR_EERR] = 1'b0;
                        s_d.st = ST_ARRAY;
                     end
                  end
                  default: s_d.refused = 1'b0;
               endcase
            end
         end
         ST_WRR: begin
            s_d.cnt = s_q.cnt - 4'h1;
            if (s_q.cnt == 4'h1) begin
               s_d.st = ST_IDLE;
            end
         end
         ST_ARRAY: begin
            if (i_OP_DONE) begin
               if (i_OP_FAIL) begin
                  s_d.sr[fscr_pkg::SR_PERR] = s_q.prog;
                  s_d.sr[fscr_pkg::SR_EERR] = !s_q.prog;
               end
               s_d.st = ST_IDLE;
            end
         end
         default: s_d.st = ST_IDLE;
      endcase
      s_d.sr[fscr_pkg::SR_WIP] = (s_d.st != ST_IDLE) || i_OTHER_BUSY;
      s_d.cr[fscr_pkg::CR_RFU] = 1'b0;
      s_d.sr_out = s_d.sr;
      s_d.cr_out = s_d.cr;
      if (I_SRST) begin
         s_d.st = ST_IDLE;
         s_d.sr = fscr_pkg::SR_RST;
         // Non-volatile fields survive a reset; the protect bits only when they are not volatile.
         s_d.sr[fscr_pkg::SR_SWD] = s_q.sr[fscr_pkg::SR_SWD];
         if (!s_q.cr[fscr_pkg::CR_BPVOL]) begin
            s_d.sr[4:2] = s_q.sr[4:2];
         end
         s_d.cr = s_q.cr;
         s_d.cr[fscr_pkg::CR_FREEZE] = 1'b0;
         s_d.cnt = 4'h0;
         s_d.prog = 1'b0;
         s_d.refused = 1'b0;
         s_d.start_p = 1'b0;
         s_d.start_e = 1'b0;
         s_d.sr_out = s_d.sr;
         s_d.cr_out = s_d.cr;
      end
   end

   always_ff @(posedge I_MCLK) begin
      s_q <= s_d;
   end

   assign o_STATUS = s_q.sr_out;
   assign o_CONFIG = s_q.cr_out;
   assign o_PROG_START = s_q.start_p;
   assign o_ERASE_START = s_q.start_e;
   assign o_CMD_REFUSED = s_q.refused;
   assign o_LATENCY_CODE = s_q.cr_out[fscr_pkg::CR_LC_HI:fscr_pkg::CR_LC_LO];
   assign o_QUAD_EN = s_q.cr_out[fscr_pkg::CR_QUAD];
   assign o_PARAM_TOP = s_q.cr_out[fscr_pkg::CR_PARAM];
   assign o_OTP_LOCK = s_q.cr_out[fscr_pkg::CR_FREEZE];

   //////////////////////////////////////////////////////////////////////////////////////////////
   sequence wrr_take;
      s_q.st == ST_IDLE && i_CMD_VALID && !i_OTHER_BUSY && i_CMD == fscr_pkg::FSCR_CMD_WRR;
   endsequence

   sequence write_enable_cmd_take;
      s_q.st == ST_IDLE && i_CMD_VALID && !i_OTHER_BUSY && i_CMD == fscr_pkg::FSCR_CMD_WRITE_ENABLE_CMD;
   endsequence

   sequence write_disable_cmd_take;
      s_q.st == ST_IDLE && i_CMD_VALID && !i_OTHER_BUSY && i_CMD == fscr_pkg::FSCR_CMD_WRITE_DISABLE_CMD;
   endsequence

   // A register write that both the latch and the protect pin let through.
   sequence wrr_open;
      wrr_take and ((!s_q.sr[7] || s_q.wp_s2) && s_q.sr[1]);
   endsequence

   AST_WRR_LOCKED: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      wrr_take and (s_q.sr[7] && !s_q.wp_s2) |=> $stable(o_STATUS[7:2]) && o_CMD_REFUSED)
      else $error("locked register write changed status");
   AST_WRR_UNLOCKED: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      wrr_take and (!s_q.sr[7] && s_q.sr[1]) |=> o_STATUS[0] && !o_CMD_REFUSED)
      else $error("unprotected register write was refused");
   AST_ERR_FLAG: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      s_q.st == ST_ARRAY && i_OP_DONE && i_OP_FAIL |=> o_STATUS[6] ^ o_STATUS[5])
      else $error("failed operation raised no error flag");
   AST_PROTECT_ALL: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      s_q.st == ST_IDLE && i_CMD_VALID && !i_OTHER_BUSY && i_CMD == fscr_pkg::FSCR_CMD_ERASE
      && s_q.sr[4:2] == 3'h7 |=> !o_ERASE_START && o_CMD_REFUSED)
      else $error("erase inside protected range started");
   AST_WEL_NEEDED: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      o_PROG_START || o_ERASE_START |-> $past(s_q.sr[1]))
      else $error("array operation started without write enable");
   AST_WEL_ONLY_CMD: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      $changed(o_STATUS[1]) |-> $past(I_SRST) || $past(i_CMD_VALID)
      && ($past(i_CMD) == fscr_pkg::FSCR_CMD_WRITE_ENABLE_CMD || $past(i_CMD) == fscr_pkg::FSCR_CMD_WRITE_DISABLE_CMD))
      else $error("write enable latch changed without its command");
   AST_WIP_WRR: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      wrr_take and (!s_q.sr[7] && s_q.sr[1]) |=> o_STATUS[0] [*4]
      ##1 (!o_STATUS[0] || $past(i_OTHER_BUSY)))
      else $error("busy bit wrong during register write");
   AST_FREEZE_HOLD: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      o_CONFIG[0] && $past(o_CONFIG[0]) |-> $stable(o_STATUS[4:2]) && $stable(o_CONFIG[5]))
      else $error("frozen protection bits changed");
   AST_WRR_NO_WEL: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      wrr_take and (!s_q.sr[1]) |=> o_CMD_REFUSED && $stable(o_STATUS[7:2]))
      else $error("register write taken without write enable");
   AST_WEL_SET: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      write_enable_cmd_take |=> o_STATUS[1])
      else $error("write enable command did not set the latch");
   AST_WEL_CLEAR: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      write_disable_cmd_take |=> !o_STATUS[1])
      else $error("write disable command did not clear the latch");
   AST_ERR_RESET: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      $past(I_SRST) |-> o_STATUS[6:5] == 2'h0)
      else $error("error flags not clear after reset");
   AST_WIP_ARRAY: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      s_q.st == ST_ARRAY |-> o_STATUS[0])
      else $error("busy bit low during array operation");
   AST_LAT_WRITE: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      wrr_open and i_WR_CONFIG_VALID |=> o_LATENCY_CODE == $past(i_WR_CONFIG[7:6]))
      else $error("latency code not taken from register write");
   AST_PSTART_KEEP: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      $past(o_CONFIG[5]) |-> o_CONFIG[5])
      else $error("one-time protect start bit was cleared");
   AST_BPVOL_KEEP: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      $past(o_CONFIG[3]) |-> o_CONFIG[3])
      else $error("one-time volatility bit was cleared");
   AST_NV_IMAGE: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      nv_we |-> ##2 nv_rdata == $past(s_d.sr, 2))
      else $error("non-volatile image does not hold the written status");
   AST_PARAM_KEEP: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      $past(o_CONFIG[2]) |-> o_CONFIG[2])
      else $error("one-time placement bit was cleared");
   AST_QUAD_WRITE: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      wrr_open and i_WR_CONFIG_VALID |=> o_QUAD_EN == $past(i_WR_CONFIG[1]))
      else $error("quad enable not taken from register write");
   AST_FREEZE_RESET: assert property (@(posedge I_MCLK) disable iff (I_SRST)
      $past(I_SRST) |-> !o_CONFIG[0])
      else $error("freeze bit still set after reset");
endmodule : fscr_regs

// *** fscr_pkg.sv ***
package fscr_pkg;
   // Status register bit positions.
   localparam int SR_SWD = 7;
   localparam int SR_PERR = 6;
   localparam int SR_EERR = 5;
   localparam int SR_BP_HI = 4;
   localparam int SR_BP_LO = 2;
   localparam int SR_WEL = 1;
   localparam int SR_WIP = 0;
   // Configuration register bit positions.
   localparam int CR_LC_HI = 7;
   localparam int CR_LC_LO = 6;
   localparam int CR_PSTART = 5;
   localparam int CR_RFU = 4;
   localparam int CR_BPVOL = 3;
   localparam int CR_PARAM = 2;
   localparam int CR_QUAD = 1;
   localparam int CR_FREEZE = 0;
   // Values as delivered; reset loads SR_RST into the volatile status bits only.
   localparam logic [7:0] SR_RST = 8'h00;
   localparam logic [7:0] CR_RST = 8'h00;
   // Busy time of a register write in cycles.
   localparam int WR_BUSY_CYC = 4;
   // Command codes seen on the command port.
   typedef enum logic [2:0] {
      FSCR_CMD_NONE = 3'h0,
      FSCR_CMD_WRITE_ENABLE_CMD = 3'h1,
      FSCR_CMD_WRITE_DISABLE_CMD = 3'h2,
      FSCR_CMD_WRR = 3'h3,
      FSCR_CMD_PROG = 3'h4,
      FSCR_CMD_ERASE = 3'h5
   } fscr_cmd_e;
endpackage : fscr_pkg

// *** fscr_nvstore.sv ***
// Small non-volatile store of two words, of which only word 0 (the status byte) is written; read data come from a register.
module fscr_nvstore (
   // Clock.
   input wire logic i_clk,
   // Write port.
   input wire logic i_we,
   input wire logic i_addr,
   input wire logic [7:0] i_wdata,
   // Read port.
   input wire logic i_raddr,
   output logic [7:0] o_rdata
);
   // Both words are blank as delivered.
   logic [7:0] mem_q [0:1] = '{8'h00, 8'h00};
   always_ff @(posedge i_clk) begin
      if (i_we) begin
         mem_q[i_addr] <= i_wdata;
      end
      o_rdata <= mem_q[i_raddr];
   end
endmodule : fscr_nvstore

// *** fscr_host.sv ***
// Far-side model: issues commands and plays the array engine.
module fscr_host (
   // Clock.
   input wire logic i_clk,
   // Engine control from the block; fail mode from the test.
   input wire logic i_prog_start,
   input wire logic i_erase_start,
   input wire logic i_fail_mode,
   // Command port to the block.
   output logic [2:0] o_cmd,
   output logic o_cmd_valid,
   output logic [7:0] o_wr_status,
   output logic [7:0] o_wr_config,
   output logic o_wr_config_valid,
   output logic [7:0] o_sector,
   // Engine answer.
   output logic o_op_done,
   output logic o_op_fail
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   initial begin
      o_cmd = 3'h0;
      o_cmd_valid = 1'b0;
      o_wr_status = 8'h00;
      o_wr_config = 8'h00;
      o_wr_config_valid = 1'b0;
      o_sector = 8'h00;
      o_op_done = 1'b0;
      o_op_fail = 1'b0;
   end
   // One-cycle command pulse with its qualifiers.
   task automatic send(input logic [2:0] c, input logic [7:0] s, input logic [7:0] f,
                       input logic fv, input logic [7:0] sec);
      @(posedge i_clk);
      o_cmd <= c;
      o_cmd_valid <= 1'b1;
      o_wr_status <= s;
      o_wr_config <= f;
      o_wr_config_valid <= fv;
      o_sector <= sec;
      @(posedge i_clk);
      o_cmd_valid <= 1'b0;
      o_wr_config_valid <= 1'b0;
   endtask : send
   // The engine ends each started operation three cycles later.
   always @(posedge i_clk) begin
      o_op_done <= 1'b0;
      o_op_fail <= 1'b0;
      if (i_prog_start || i_erase_start) begin
         cnt <= 3;
      end else if (cnt == 1) begin
         o_op_done <= 1'b1;
         o_op_fail <= i_fail_mode;
         cnt <= 0;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule : fscr_host

// *** fscr_regs_test.sv ***
module fscr_regs_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, srst = 1'b1, other_busy = 1'b0, wp_n = 1'b1, fail_mode = 1'b0;
   logic [2:0] cmd;
   logic cmd_valid, cfg_valid, op_done, op_fail, ps, es, refused, quad, ptop, lock;
   logic [7:0] wst, wcf, sec, st, cf;
   logic [1:0] lat;
   int error_cnt = 0;
   int checks = 0;
   initial begin
      forever #10 clk = ~clk;
   end
   fscr_host host (.i_clk(clk), .i_prog_start(ps), .i_erase_start(es), .i_fail_mode(fail_mode),
      .o_cmd(cmd), .o_cmd_valid(cmd_valid), .o_wr_status(wst), .o_wr_config(wcf),
      .o_wr_config_valid(cfg_valid), .o_sector(sec), .o_op_done(op_done), .o_op_fail(op_fail));
   fscr_regs #(.ADDR_W(8)) uut (.I_MCLK(clk), .I_SRST(srst), .i_CMD(cmd), .i_CMD_VALID(cmd_valid),
      .i_WR_STATUS(wst), .i_WR_CONFIG(wcf), .i_WR_CONFIG_VALID(cfg_valid), .i_SECTOR(sec),
      .i_OP_DONE(op_done), .i_OP_FAIL(op_fail), .i_OTHER_BUSY(other_busy), .i_WP_N(wp_n),
      .o_STATUS(st), .o_CONFIG(cf), .o_PROG_START(ps), .o_ERASE_START(es),
      .o_CMD_REFUSED(refused), .o_LATENCY_CODE(lat), .o_QUAD_EN(quad), .o_PARAM_TOP(ptop),
      .o_OTP_LOCK(lock));
   //////////////////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      if (error_cnt == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : tick
   task automatic wait_idle;
      for (int i = 0; i < 40; i++) begin
         tick(1);
         if (st[0] === 1'b0) return;
      end
      error_cnt++;
      give_verdict();
   endtask : wait_idle
   // Sends one command and checks whether the block refused it.
   task automatic go(input logic [2:0] c, input logic [7:0] s, input logic [7:0] f,
                     input logic fv, input logic [7:0] sc, input logic rf);
      host.send(c, s, f, fv, sc);
      #1;
      cmp("refused", {7'h0, rf}, {7'h0, refused});
      wait_idle();
   endtask : go
   //////////////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      cmp("status", 8'h00, st);
      cmp("config", 8'h00, cf);
      go(3'h3, 8'h9c, 8'h00, 1'b0, 8'h00, 1'b1);
      go(3'h4, 8'h00, 8'h00, 1'b0, 8'h10, 1'b1);
      cmp("status", 8'h00, st);
   endtask : t_reset
   task automatic t_write;
      go(3'h1, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0);
      cmp("status", 8'h02, st);
      host.send(3'h3, 8'h44, 8'ha6, 1'b1, 8'h00);
      #1;
      cmp("status", 8'h07, st);
      tick(3);
      cmp("busy", 8'h01, {7'h0, st[0]});
      tick(1);
      cmp("status", 8'h06, st);
      cmp("config", 8'ha6, cf);
      cmp("modes", 8'h16, {3'h0, lat, quad, ptop, lock});
   endtask : t_write
   task automatic t_protect;
      go(3'h4, 8'h00, 8'h00, 1'b0, 8'h00, 1'b1);
      fail_mode <= 1'b1;
      host.send(3'h4, 8'h00, 8'h00, 1'b0, 8'hff);
      #1;
      cmp("start", 8'h01, {7'h0, ps});
      wait_idle();
      cmp("status", 8'h46, st);
      host.send(3'h5, 8'h00, 8'h00, 1'b0, 8'hfe);
      #1;
      cmp("refused", 8'h00, {7'h0, refused});
      cmp("start", 8'h01, {7'h0, es});
      wait_idle();
      cmp("status", 8'h26, st);
      fail_mode <= 1'b0;
      go(3'h3, 8'h1c, 8'h00, 1'b0, 8'h00, 1'b0);
      go(3'h5, 8'h00, 8'h00, 1'b0, 8'h80, 1'b1);
      cmp("status", 8'h3e, st);
   endtask : t_protect
   task automatic t_wp;
      go(3'h3, 8'h9c, 8'h00, 1'b0, 8'h00, 1'b0);
      wp_n <= 1'b0;
      tick(3);
      go(3'h3, 8'h00, 8'h00, 1'b0, 8'h00, 1'b1);
      cmp("status", 8'hbe, st);
      wp_n <= 1'b1;
      tick(3);
      go(3'h3, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0);
      wp_n <= 1'b0;
      tick(3);
      go(3'h3, 8'h08, 8'h00, 1'b0, 8'h00, 1'b0);
      cmp("status", 8'h2a, st);
   endtask : t_wp
   task automatic t_freeze;
      go(3'h3, 8'h08, 8'ha7, 1'b1, 8'h00, 1'b0);
      cmp("lock", 8'h01, {7'h0, lock});
      go(3'h3, 8'h10, 8'ha7, 1'b1, 8'h00, 1'b0);
      cmp("status", 8'h2a, st);
      other_busy <= 1'b1;
      tick(2);
      cmp("busy", 8'h01, {7'h0, st[0]});
      other_busy <= 1'b0;
      wait_idle();
   endtask : t_freeze
   task automatic t_rereset;
      srst <= 1'b1;
      tick(1);
      srst <= 1'b0;
      cmp("status", 8'h08, st);
      cmp("config", 8'ha6, cf);
      tick(2);
      go(3'h1, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0);
      go(3'h2, 8'h00, 8'h00, 1'b0, 8'h00, 1'b0);
      cmp("status", 8'h08, st);
   endtask : t_rereset
   initial begin
      tick(8);
      srst <= 1'b0;
      tick(2);
      t_reset();
      t_write();
      t_protect();
      t_wp();
      t_freeze();
      t_rereset();
      give_verdict();
   end
endmodule : fscr_regs_test
